/* hdl/rx_link_ctrl_pkg.sv */
// Package with register map, field layout, reset values and timing constants
package rx_link_ctrl_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] OFF_GENERAL = 8'h00;
  localparam logic [7:0] OFF_LAT0 = 8'h04;
  localparam logic [7:0] OFF_LAT1 = 8'h08;
  localparam logic [7:0] OFF_DLY0 = 8'h0C;
  localparam logic [7:0] OFF_DLY1 = 8'h10;
  localparam logic [7:0] OFF_VAR0 = 8'h14;
  localparam logic [7:0] OFF_VAR1 = 8'h18;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  // Read-only lock status word, kept apart since control bit 0 belongs to link 0
  localparam logic [7:0] OFF_PLL_STATUS = 8'h24;
  // Field positions in receiver_general_control; POS_PLL_LOCK is bit 0 of the lock status word
  localparam int POS_PLL_LOCK = 0;
  localparam int POS_LINK_EN_LO = 0;
  localparam int POS_LINK_PAGE = 2;
  localparam int POS_LINK_MODE = 3;
  // Field positions in the interrupt status and mask registers
  localparam int POS_EV_LOCK_GAIN = 0;
  localparam int POS_EV_LOCK_LOSS = 1;
  localparam int POS_EV_LAT0 = 2;
  localparam int POS_EV_LAT1 = 3;
  localparam int NUM_EVENTS = 4;
  // Width of the six-bit delay and latency fields
  localparam int FIELD_W = 6;
  localparam int NUM_LINKS = 2;
  // Values after reset
  localparam logic [1:0] RST_LINK_EN = 2'h0;
  localparam logic RST_PAGE = 1'b0;
  localparam logic [5:0] RST_DELAY = 6'h00;
  localparam logic [5:0] RST_VAR = 6'h00;
  localparam logic [3:0] RST_MASK = 4'h0;
  // Processing clock is the system clock divided by this count
  localparam int PCLK_DIV = 4;
  localparam logic [1:0] PCLK_LAST = 2'(PCLK_DIV - 1);
endpackage : rx_link_ctrl_pkg

/* hdl/link_timing_if.sv */
// Interface carrying one link's multiframe timing signals between modules
interface link_timing_if (
  input wire logic clk,
  input wire logic rstn
);
  logic tick; // Processing-clock enable pulse
  logic enable; // Link is brought up
  logic local_lmfc; // Local multiframe clock pulse
  logic [5:0] delay; // Programmed delay in processing cycles
  logic rx_lmfc; // Delayed receive multiframe clock pulse
  logic boundary; // Last-arriving multiframe boundary pulse
  logic [5:0] latency; // Measured latency, held
  logic done; // One-cycle pulse when latency is updated
  modport delayer (input clk, rstn, tick, enable, local_lmfc, delay, output rx_lmfc);
  modport meter (input clk, rstn, tick, enable, rx_lmfc, boundary, output latency, done);
endinterface : link_timing_if

/* hdl/frame_clock_delayer.sv */
// Delays the local multiframe clock by a count of processing cycles
module frame_clock_delayer (
  link_timing_if.delayer lt
);
  logic [5:0] count; // Processing cycles still to wait
  logic armed; // A delayed pulse is pending

  // A new local pulse with a nonzero delay restarts the wait; a pending one is dropped
  always_ff @(posedge lt.clk or negedge lt.rstn) begin
    if (!lt.rstn) begin
      count <= 6'h00;
      armed <= 1'b0;
      lt.rx_lmfc <= 1'b0;
    end else begin
      lt.rx_lmfc <= 1'b0;
      if (!lt.enable) begin
        armed <= 1'b0;
      end else if (lt.local_lmfc) begin
        if (lt.delay == 6'h00) begin
          lt.rx_lmfc <= 1'b1;
        end else begin
          armed <= 1'b1;
          count <= lt.delay;
        end
      end else if (armed && lt.tick) begin
        count <= count - 6'h01;
        if (count == 6'h01) begin
          armed <= 1'b0;
          lt.rx_lmfc <= 1'b1;
        end
      end
    end
  end

  zero_delay_a: assert property (@(posedge lt.clk) disable iff (!lt.rstn)
    lt.enable && lt.local_lmfc && lt.delay == 6'h00 |=> lt.rx_lmfc)
    else $error("zero delay did not pass the pulse at once");
  off_quiet_a: assert property (@(posedge lt.clk) disable iff (!lt.rstn)
    !lt.enable |=> !lt.rx_lmfc)
    else $error("disabled link produced a receive multiframe pulse");
endmodule : frame_clock_delayer

/* hdl/latency_meter.sv */
// Counts processing cycles from receive multiframe clock to the last boundary
module latency_meter (
  link_timing_if.meter lt
);
  logic [5:0] count; // Running count, saturates at all ones
  logic running; // Waiting for the boundary

  // The count saturates rather than wraps so a late boundary reads as 63
  always_ff @(posedge lt.clk or negedge lt.rstn) begin
    if (!lt.rstn) begin
      count <= 6'h00;
      running <= 1'b0;
      lt.latency <= 6'h00;
      lt.done <= 1'b0;
    end else begin
      lt.done <= 1'b0;
      if (!lt.enable) begin
        running <= 1'b0;
      end else if (lt.boundary && (running || lt.rx_lmfc)) begin
        lt.latency <= lt.rx_lmfc ? 6'h00 : count;
        lt.done <= 1'b1;
        running <= 1'b0;
      end else if (lt.rx_lmfc) begin
        running <= 1'b1;
        count <= 6'h00;
      end else if (running && lt.tick && count != 6'h3F) begin
        count <= count + 6'h01;
      end
    end
  end

  sequence boundary_seen_s;
    lt.enable && running && !lt.rx_lmfc && lt.boundary;
  endsequence
  capture_a: assert property (@(posedge lt.clk) disable iff (!lt.rstn)
    boundary_seen_s |=> lt.done && lt.latency == $past(count))
    else $error("latency not captured at the boundary");
endmodule : latency_meter

/* hdl/rx_link_ctrl.sv */
// Control and status registers of the serial receiver link, Wishbone slave
//
// Notes on behaviour
// - Bit 0 reads high while lane PLL locked; general bit 0 is link 0 enable, lock is bit 0 of the lock word.
// - Bit 3 reads link count: 0 one, 1 two.
// - Bit 2 selects which link map is visible.
// - Enable bit 0 is link 0, bit 1 link 1.
// - Each link reports six-bit measured multiframe latency.
// - Each link delays receive multiframe clock by count.
//
// Our own choices: the register addresses and register access over Wishbone.
module rx_link_ctrl
  import rx_link_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic lane_pll_lock_pin,
  input wire logic dual_link_pin,
  input wire logic local_lmfc,
  input wire logic [1:0] lane_boundary,
  output logic [1:0] link_enable,
  output logic link_map_page,
  output logic [1:0] rx_lmfc,
  output logic irq
);

  // Match of address bits 7 to 2 against a word offset, used by read and write decode
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    reg_hit = (adr[7:2] == off[7:2]);
  endfunction : reg_hit

  // Pin synchronisers; the first stage feeds only the second
  logic lock_meta; // First stage of lock pin
  logic lock_sync; // Usable lock level
  logic lock_prev; // Lock level one cycle ago, for edge events
  logic dual_meta; // First stage of link count strap
  logic dual_sync; // Usable link count level

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      lock_prev <= 1'b0;
      dual_meta <= 1'b0;
      dual_sync <= 1'b0;
    end else begin
      lock_meta <= lane_pll_lock_pin;
      lock_sync <= lock_meta;
      lock_prev <= lock_sync;
      dual_meta <= dual_link_pin;
      dual_sync <= dual_meta;
    end
  end

  // Processing-clock enable divider; every link counts on this pulse
  logic [1:0] div_count; // Position within one processing cycle
  logic pclk_tick; // One-cycle enable at the processing rate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_count <= 2'h0;
      pclk_tick <= 1'b0;
    end else begin
      pclk_tick <= (div_count == PCLK_LAST);
      div_count <= (div_count == PCLK_LAST) ? 2'h0 : div_count + 2'h1;
    end
  end

  // Software-owned control state
  logic [1:0] link_en; // Bring-up bits as stored
  logic page; // Link map page select
  logic [5:0] delay [NUM_LINKS]; // Multiframe clock delay per link
  logic [5:0] variation [NUM_LINKS]; // Variation field, stored only
  logic [3:0] irq_status; // Sticky event bits
  logic [3:0] irq_mask; // Enables for irq

  // Bus access decode
  logic bus_req; // Cycle and strobe both high
  logic wr_take; // Write commits at the edge where ack is seen
  logic wr_low; // Write touches the low byte lane
  logic hit_gen, hit_lat0, hit_lat1, hit_dly0, hit_dly1;
  logic hit_var0, hit_var1, hit_st, hit_mk;
  logic hit_lock; // Lock status word selected
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign wr_take = bus_req && wb_we_i && wb_ack_o;
  assign wr_low = wr_take && wb_sel_i[0];
  assign hit_gen = reg_hit(wb_adr_i, OFF_GENERAL);
  assign hit_lat0 = reg_hit(wb_adr_i, OFF_LAT0);
  assign hit_lat1 = reg_hit(wb_adr_i, OFF_LAT1);
  assign hit_dly0 = reg_hit(wb_adr_i, OFF_DLY0);
  assign hit_dly1 = reg_hit(wb_adr_i, OFF_DLY1);
  assign hit_var0 = reg_hit(wb_adr_i, OFF_VAR0);
  assign hit_var1 = reg_hit(wb_adr_i, OFF_VAR1);
  assign hit_st = reg_hit(wb_adr_i, OFF_IRQ_STATUS);
  assign hit_mk = reg_hit(wb_adr_i, OFF_IRQ_MASK);
  // Lock word ignores writes; software only polls it
  assign hit_lock = reg_hit(wb_adr_i, OFF_PLL_STATUS);

  // Link 1 only exists with two links, so its bit is forced off otherwise
  logic [1:0] next_link_en; // Stored bring-up bits after this cycle
  logic [1:0] wr_link_en; // Value software writes, gated by link count
  assign wr_link_en = {wb_dat_i[1] & dual_sync, wb_dat_i[0]};
  assign next_link_en = (wr_low && hit_gen) ? wr_link_en
                      : {link_en[1] & dual_sync, link_en[0]};

  // General control: only bits 2 to 0 store; bit 3 and up are not writable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_en <= RST_LINK_EN;
      page <= RST_PAGE;
    end else begin
      link_en <= next_link_en;
      if (wr_low && hit_gen) begin
        page <= wb_dat_i[POS_LINK_PAGE];
      end
    end
  end

  // Delay and variation fields; bits 7 to 6 are dropped on write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      delay[0] <= RST_DELAY;
      delay[1] <= RST_DELAY;
      variation[0] <= RST_VAR;
      variation[1] <= RST_VAR;
    end else if (wr_low) begin
      if (hit_dly0) delay[0] <= wb_dat_i[5:0];
      if (hit_dly1) delay[1] <= wb_dat_i[5:0];
      if (hit_var0) variation[0] <= wb_dat_i[5:0];
      if (hit_var1) variation[1] <= wb_dat_i[5:0];
    end
  end

  // Per-link timing: delayer feeds meter through one interface per link
  logic [5:0] latency [NUM_LINKS]; // Held latency per link
  logic [1:0] lat_done; // Latency update pulses
  logic [1:0] rx_pulse; // Delayed multiframe pulses

  for (genvar i = 0; i < NUM_LINKS; i++) begin : g_link
    link_timing_if lt (.clk(clk), .rstn(rstn));
    assign lt.tick = pclk_tick;
    assign lt.enable = link_enable[i];
    assign lt.local_lmfc = local_lmfc;
    assign lt.delay = delay[i];
    assign lt.boundary = lane_boundary[i];
    assign latency[i] = lt.latency;
    assign lat_done[i] = lt.done;
    assign rx_pulse[i] = lt.rx_lmfc;
    frame_clock_delayer u_delay (.lt(lt));
    latency_meter u_meter (.lt(lt));
  end

  // The delayer output is already a flop, so it leaves the block directly
  assign rx_lmfc = rx_pulse;

  // Events; a set in the same cycle as a write-one clear wins
  logic [3:0] events; // This cycle's events
  logic [3:0] clr_bits; // Write-one-to-clear pattern
  logic [3:0] next_status; // Sticky bits after this cycle
  assign events = {lat_done[1], lat_done[0], lock_prev & ~lock_sync, lock_sync & ~lock_prev};
  assign clr_bits = (wr_low && hit_st) ? wb_dat_i[3:0] : 4'h0;
  assign next_status = (irq_status & ~clr_bits) | events;

  // Interrupt state and the registered level output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_status <= 4'h0;
      irq_mask <= RST_MASK;
      irq <= 1'b0;
    end else begin
      irq_status <= next_status;
      if (wr_low && hit_mk) irq_mask <= wb_dat_i[3:0];
      irq <= |(next_status & (wr_low && hit_mk ? wb_dat_i[3:0] : irq_mask));
    end
  end

  // Read data; unmapped words and reserved bits read as zero
  logic [7:0] gen_rd; // General control as read
  logic [7:0] lock_rd; // Lock status word, only bit 0 is live
  logic [7:0] rd_byte; // Selected register
  assign gen_rd = {4'h0, dual_sync, page, link_en};
  // Synchronised level, so a read never sees a metastable lock bit
  assign lock_rd = {7'h00, lock_sync};
  assign rd_byte = hit_gen ? gen_rd
                 : hit_lat0 ? {2'h0, latency[0]}
                 : hit_lat1 ? {2'h0, latency[1]}
                 : hit_dly0 ? {2'h0, delay[0]}
                 : hit_dly1 ? {2'h0, delay[1]}
                 : hit_var0 ? {2'h0, variation[0]}
                 : hit_var1 ? {2'h0, variation[1]}
                 : hit_st ? {4'h0, irq_status}
                 : hit_mk ? {4'h0, irq_mask}
                 : hit_lock ? lock_rd
                 : 8'h00;

  // Ack one cycle after the request; dropped the cycle after
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // Outputs toward the receiver datapath
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_enable <= 2'h0;
      link_map_page <= 1'b0;
    end else begin
      link_enable <= next_link_en;
      link_map_page <= page;
    end
  end

  // All checks below sample on the system clock and sleep through reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence wr_gen_s;
    wr_low && hit_gen;
  endsequence
  sequence single_link_s;
    !dual_sync;
  endsequence
  // Lock edges as the event logic sees them, and a read of the lock word
  sequence lock_rise_s;
    lock_sync && !lock_prev;
  endsequence
  sequence lock_fall_s;
    !lock_sync && lock_prev;
  endsequence
  sequence lock_rd_s;
    bus_req && !wb_ack_o && hit_lock;
  endsequence

  // Bus and control word checks

  lock_track_a: assert property ($rose(lane_pll_lock_pin) |-> ##3 lock_sync)
    else $error("lock status did not follow the pin");
  link_mode_a: assert property (bus_req && !wb_ack_o && hit_gen |=>
    wb_dat_o[POS_LINK_MODE] == $past(dual_sync))
    else $error("link count bit wrong on read");
  page_out_a: assert property (wr_gen_s |=> ##1
    link_map_page == $past(wb_dat_i[POS_LINK_PAGE], 2))
    else $error("page output did not follow the write");
  link1_gate_a: assert property (single_link_s |=> !link_en[1])
    else $error("link 1 enabled with one link");
  enable_out_a: assert property (wr_gen_s ##1 1'b1 |->
    link_enable[0] == $past(wb_dat_i[POS_LINK_EN_LO], 2))
    else $error("link 0 enable did not follow the write");
  reserved_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("bits above the register read nonzero");
  gen_reserved_a: assert property (bus_req && !wb_ack_o && hit_gen |=>
    wb_dat_o[7:4] == 4'h0)
    else $error("reserved control bits read nonzero");
  delay_store_a: assert property (wr_low && hit_dly0 |=>
    delay[0] == $past(wb_dat_i[5:0]))
    else $error("delay field not stored");
  wb_ack_a: assert property (bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");
  status_set_a: assert property (lat_done[0] |=> irq_status[POS_EV_LAT0])
    else $error("latency event lost");

  // No request, no answer: a stray ack would commit a phantom write
  wb_quiet_a: assert property (!bus_req |=> !wb_ack_o)
    else $error("ack without a request");

  // Lock level and its edges are visible to software
  lock_read_a: assert property (lock_rd_s |=>
    wb_dat_o[POS_PLL_LOCK] == $past(lock_sync))
    else $error("lock status bit wrong on read");
  lock_gain_a: assert property (lock_rise_s |=> irq_status[POS_EV_LOCK_GAIN])
    else $error("lock gained event lost");
  lock_loss_a: assert property (lock_fall_s |=> irq_status[POS_EV_LOCK_LOSS])
    else $error("lock lost event lost");

  // Page moves only on a committed write to the control word
  page_hold_a: assert property (!(wr_low && hit_gen) |=> $stable(page))
    else $error("page changed without a write");

  // Read-back of the measured latency, and storage of the second delay and first variation fields
  lat_read_a: assert property (bus_req && !wb_ack_o && hit_lat0 |=>
    wb_dat_o[7:0] == {2'h0, $past(latency[0])})
    else $error("latency read back wrong");
  delay1_store_a: assert property (wr_low && hit_dly1 |=>
    delay[1] == $past(wb_dat_i[5:0]))
    else $error("second delay field not stored");
  var_store_a: assert property (wr_low && hit_var0 |=>
    variation[0] == $past(wb_dat_i[5:0]))
    else $error("variation field not stored");

  // A pending unmasked event keeps the line up unless software just touched it
  irq_level_a: assert property ((irq_status & irq_mask) != 4'h0 &&
    !(wr_low && (hit_st || hit_mk)) |=> irq)
    else $error("interrupt low while an unmasked event is pending");

endmodule : rx_link_ctrl

/* test/rx_link_ctrl_test.sv */
// Self-checking register and timing testbench for the receiver link control block
module rx_link_ctrl_test;
  import rx_link_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0; // System clock, 25 MHz
  logic rstn = 1'b0; // Active-low reset
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0; // Bus request
  logic [7:0] wb_adr_i = 8'h00; // Byte address
  logic [3:0] wb_sel_i = 4'hF; // Byte enables
  logic [31:0] wb_dat_i = 32'h0; // Write data
  logic [31:0] wb_dat_o; // Read data
  logic wb_ack_o; // Bus answer
  logic lane_pll_lock_pin = 1'b0; // PLL lock pin, starts unlocked
  logic dual_link_pin = 1'b0; // Starts in one-link mode
  logic local_lmfc = 1'b0; // Local multiframe clock pulse
  logic [1:0] lane_boundary = 2'h0; // Boundary pulses
  logic [1:0] link_enable; // Bring-up outputs
  logic link_map_page; // Map page output
  logic [1:0] rx_lmfc; // Delayed multiframe clocks
  logic irq; // Interrupt level
  int error_cnt = 0; // Mismatches seen
  int check_count = 0; // Comparisons made
  logic [31:0] rd; // Last read value
  int n; // Cycle counter for delay measurement
  localparam logic [7:0] RW_OFF [4] = '{OFF_DLY0, OFF_DLY1, OFF_VAR0, OFF_VAR1};

  rx_link_ctrl dut (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lane_pll_lock_pin(lane_pll_lock_pin),
    .dual_link_pin(dual_link_pin), .local_lmfc(local_lmfc), .lane_boundary(lane_boundary),
    .link_enable(link_enable), .link_map_page(link_map_page), .rx_lmfc(rx_lmfc), .irq(irq));

  // Free-running clock
  initial begin
    forever #20 clk = ~clk;
  end

  // Verdict and end of run, reached from the tests and the watchdog
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // Compare a value against its expectation; four-state safe
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  // Compare a count against an inclusive window, for figures that depend on tick phase
  task automatic check_rng(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_rng

  // One classic bus cycle; request held until ack is sampled, then released
  // The wait has no limit of its own: only the watchdog ends a hung cycle
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_cycle

  task automatic wb_write(input logic [7:0] adr, input logic [7:0] dat);
    wb_cycle(1'b1, adr, dat);
  endtask : wb_write

  // Read and compare in one call
  task automatic wb_check(input logic [7:0] adr, input logic [7:0] exp, input string what);
    wb_cycle(1'b0, adr, 8'h00);
    check_val(what, {24'h0, exp}, rd);
  endtask : wb_check

  // One-cycle local multiframe clock pulse, optionally with a boundary on link 0
  task automatic lmfc_pulse(input logic [1:0] bnd);
    @(posedge clk);
    local_lmfc <= 1'b1;
    @(posedge clk);
    local_lmfc <= 1'b0;
    lane_boundary <= bnd;
    @(posedge clk);
    lane_boundary <= 2'h0;
  endtask : lmfc_pulse

  // Watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, reserved tops and unmapped place
    wb_check(OFF_GENERAL, 8'h00, "general reset");
    wb_check(OFF_PLL_STATUS, 8'h00, "lock reset");
    for (int i = 0; i < 4; i++) begin
      wb_check(RW_OFF[i], 8'h00, "field reset");
      wb_write(RW_OFF[i], 8'hFF);
      wb_check(RW_OFF[i], 8'h3F, "reserved top bits");
    end
    // A write with the low byte lane off must leave the field alone
    wb_sel_i <= 4'hE;
    wb_write(OFF_DLY1, 8'h15);
    wb_sel_i <= 4'hF;
    wb_check(OFF_DLY1, 8'h3F, "low lane off");
    wb_write(8'h28, 8'hAA);
    wb_check(8'h28, 8'h00, "unmapped");
    // One-link mode: link 1 enable refused
    wb_write(OFF_GENERAL, 8'h03);
    wb_check(OFF_GENERAL, 8'h01, "single enable");
    check_val("link_enable single", 32'(2'b01), 32'(link_enable));
    // Two-link mode: count bit, page and both enables
    @(posedge clk);
    dual_link_pin <= 1'b1;
    repeat (6) @(posedge clk);
    wb_check(OFF_GENERAL, 8'h09, "mode bit");
    wb_write(OFF_GENERAL, 8'hF7);
    wb_check(OFF_GENERAL, 8'h0F, "dual general");
    check_val("link_enable dual", 32'(2'b11), 32'(link_enable));
    check_val("map page", 32'(1'b1), 32'(link_map_page));
    // Lock gained and lost events
    @(posedge clk);
    lane_pll_lock_pin <= 1'b1;
    repeat (6) @(posedge clk);
    wb_check(OFF_IRQ_STATUS, 8'h01, "lock gained");
    wb_check(OFF_PLL_STATUS, 8'h01, "lock level");
    wb_write(OFF_IRQ_STATUS, 8'h01);
    lane_pll_lock_pin <= 1'b0;
    repeat (6) @(posedge clk);
    wb_check(OFF_IRQ_STATUS, 8'h02, "lock lost");
    wb_check(OFF_PLL_STATUS, 8'h00, "unlock level");
    wb_write(OFF_IRQ_STATUS, 8'h02);
    wb_check(OFF_IRQ_STATUS, 8'h00, "status cleared");
    // Zero delay: receive clock one cycle after local; link 1 disabled ignores it
    // Delays are programmed while link 0 is already up; the control write then takes link 1 down
    wb_write(OFF_DLY0, 8'h00);
    wb_write(OFF_DLY1, 8'h00);
    wb_write(OFF_GENERAL, 8'h01);
    // The page output trails the stored page by one cycle
    repeat (2) @(posedge clk);
    check_val("map page low", 32'(1'b0), 32'(link_map_page));
    lmfc_pulse(2'b01);
    check_val("rx_lmfc zero delay", 32'(2'b01), 32'(rx_lmfc));
    repeat (3) @(posedge clk);
    wb_check(OFF_LAT0, 8'h00, "latency zero");
    // Event masked: no interrupt; unmasked: interrupt; cleared: gone
    wb_check(OFF_IRQ_STATUS, 8'h04, "latency event");
    check_val("irq masked", 32'(1'b0), 32'(irq));
    wb_write(OFF_IRQ_MASK, 8'h04);
    @(posedge clk);
    check_val("irq unmasked", 32'(1'b1), 32'(irq));
    wb_write(OFF_IRQ_STATUS, 8'h04);
    @(posedge clk);
    check_val("irq cleared", 32'(1'b0), 32'(irq));
    // Latency saturates at the six-bit limit
    lmfc_pulse(2'b00);
    repeat (300) @(posedge clk);
    lane_boundary <= 2'b01;
    @(posedge clk);
    lane_boundary <= 2'b00;
    repeat (3) @(posedge clk);
    wb_check(OFF_LAT0, 8'h3F, "latency saturated");
    // Programmed delay of two processing cycles
    wb_write(OFF_DLY0, 8'h02);
    lmfc_pulse(2'b00);
    n = 2;
    while (rx_lmfc[0] !== 1'b1 && n < 40) begin
      check_val("link1 idle", 32'(1'b0), 32'(rx_lmfc[1]));
      @(posedge clk);
      n++;
    end
    check_rng("delayed rx_lmfc", PCLK_DIV, 2 * PCLK_DIV + 2, n);
    wb_write(OFF_IRQ_STATUS, 8'h0F);
    end_of_test();
  end
endmodule : rx_link_ctrl_test
